// ### test/vout_host_model.sv
// Purpose: host side that writes the converter configuration
// Assumes: strobes launched at the falling clock edge
// Notes: data lines are inverted once a strobe drops, so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module vout_host_model
(
  input wire logic clk_i,
  output logic cfg_wr_o,
  output logic setpoint_wr_o,
  output logic [1:0] range_o,
  output logic [1:0] ss_o,
  output logic [1:0] ramp_o,
  output logic [7:0] code_o
);
  initial
  begin
    cfg_wr_o = 1'b0;
    setpoint_wr_o = 1'b0;
    range_o = 2'h0;
    ss_o = 2'h0;
    ramp_o = 2'h0;
    code_o = 8'h00;
  end
  task automatic wr_cfg(input logic [1:0] r, input logic [1:0] s, input logic [1:0] p);
    @(negedge clk_i);
    range_o = r;
    ss_o = s;
    ramp_o = p;
    cfg_wr_o = 1'b1;
    @(negedge clk_i);
    cfg_wr_o = 1'b0;
    range_o = ~r;
    ss_o = ~s;
    ramp_o = ~p;
  endtask
  task automatic wr_set(input logic [7:0] c);
    @(negedge clk_i);
    code_o = c;
    setpoint_wr_o = 1'b1;
    @(negedge clk_i);
    setpoint_wr_o = 1'b0;
    code_o = ~c;
  endtask
endmodule // vout_host_model
`default_nettype wire

// ### test/vout_setpoint_dvs_mode_ctrl_bench.sv
// Purpose: self-checking bench for setpoint, soft start, scaling and mode select
// Assumes: two shortest soft start counts cut to 20/40 cycles; longer ones keep defaults, unused here
// Notes: inputs change at the falling edge only
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end
module vout_setpoint_dvs_mode_ctrl_bench;
  logic clk, rstn, init, i2c_var, en, frc, mode, sv, sec;
  logic [1:0] strap, addr, rng;
  logic cfg_wr, set_wr, done, ss, ramping, fccm, ps, align, extc;
  logic [1:0] h_rng, h_ss, h_ramp;
  logic [7:0] h_code, tgt, refc;
  logic [21:0] tgt_uv, ref_uv;
  logic [31:0] seed = 32'hcd68cc1a;
  logic [7:0] c;
  int comparisons = 0, miscompares = 0, cycles = 0, i, k;
  int strap_tab [4] = '{8'h46, 8'h5a, 8'h78, 8'h5f};
  vout_host_model u_vout_host_model (.clk_i(clk), .cfg_wr_o(cfg_wr), .setpoint_wr_o(set_wr),
    .range_o(h_rng), .ss_o(h_ss), .ramp_o(h_ramp), .code_o(h_code));
  vout_setpoint_dvs_mode_ctrl #(.SS_500US_CYC(20), .SS_1MS_CYC(40))
  u_vout_setpoint_dvs_mode_ctrl (.clk_sys_i(clk), .rstn_i(rstn), .init_i(init),
    .voltage_select_strap_i(strap), .i2c_variant_i(i2c_var), .enable_i(en), .cfg_wr_i(cfg_wr),
    .range_select_i(h_rng), .soft_start_duration_i(h_ss), .scaling_ramp_rate_i(h_ramp),
    .force_continuous_bit_i(frc), .setpoint_wr_i(set_wr), .setpoint_code_i(h_code),
    .mode_sync_i(mode), .sync_valid_i(sv), .secondary_i(sec), .init_done_o(done),
    .i2c_addr_sel_o(addr), .active_range_o(rng), .target_code_o(tgt), .ref_code_o(refc),
    .target_uv_o(tgt_uv), .ref_uv_o(ref_uv), .soft_start_o(ss), .ramping_o(ramping),
    .forced_continuous_switching_o(fccm), .power_save_operation_o(ps),
    .sync_align_o(align), .ext_clock_input_o(extc));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_uv(int r, int code);
    return (r == 3 ? 800000 : 400000) + code * (r == 0 ? 1250 : r == 1 ? 2500 : r == 2 ? 5000 : 10000);
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // enable, then count soft start cycles with a setpoint write in mid-run
  task automatic soft_run(input logic [7:0] mid, output int n);
    en = 1'b1;
    n = 0;
    while (ss !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    u_vout_host_model.wr_set(mid);
    n = 2;
    while (ss === 1'b1 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic step_gap(output int g);
    logic [7:0] r;
    int n;
    r = refc;
    n = 0;
    while (refc === r && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    r = refc;
    g = 0;
    while (refc === r && g < 3000)
    begin
      @(negedge clk);
      g++;
    end
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 3000 && ramping !== 1'b0; n++)
      @(negedge clk);
    repeat (3) @(negedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  initial
  begin
    {rstn, init, en, frc, mode, sv, sec} = 7'h00;
    strap = 2'h0;
    i2c_var = 1'b1;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    `CHK(done, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      strap = i[1:0];
      init = 1'b1;
      @(negedge clk);
      init = 1'b0;
      @(negedge clk);
      `CHK(tgt, strap_tab[i]);
      `CHK(addr, i);
      `CHK(rng, 2);
    end
    `CHK(done, 1'b1);
    $display("test strap defaults done");
    for (i = 0; i < 4; i++)
    begin
      c = 8'(rnd());
      k = rng;
      u_vout_host_model.wr_cfg(i[1:0], 2'h1, 2'h0);
      repeat (3) @(negedge clk);
      `CHK(rng, k);
      u_vout_host_model.wr_set(c);
      repeat (3) @(negedge clk);
      `CHK(rng, i);
      `CHK(tgt, c);
      `CHK(tgt_uv, exp_uv(i, c));
    end
    // random phase, but both variants are always visited; armed range is 3 here
    c = 8'(rnd());
    for (i = 0; i < 4; i++)
    begin
      i2c_var = c[0] ^ i[0];
      repeat (3) @(negedge clk);
      `CHK(rng, i2c_var ? 2'h3 : 2'h2);
    end
    i2c_var = 1'b1;
    u_vout_host_model.wr_cfg(2'h2, 2'h1, 2'h0);
    u_vout_host_model.wr_set(8'h20);
    $display("test range and setpoint done");
    for (i = 0; i < 16; i++)
    begin
      {mode, frc, sv, sec} = i[3:0];
      repeat (2) @(negedge clk);
      `CHK(fccm, |i[3:0]);
      `CHK(ps, ~|i[3:0]);
      `CHK(align, sv | sec);
      `CHK(extc, sec);
    end
    {mode, frc, sv, sec} = 4'h0;
    $display("test mode select done");
    soft_run(8'h30, k);
    `CHK(k, 40);
    `CHK(tgt, 8'h20);
    repeat (3) @(negedge clk);
    `CHK(tgt, 8'h30);
    `CHK(ramping, 1'b1);
    step_gap(k);
    `CHK(k, 50);
    u_vout_host_model.wr_set(8'h28);
    `CHK(tgt, 8'h30);
    wait_idle();
    `CHK(refc, 8'h30);
    `CHK(tgt, 8'h28);
    wait_idle();
    `CHK(refc, 8'h28);
    `CHK(ref_uv, exp_uv(2, 8'h28));
    $display("test soft start and scaling done");
    en = 1'b0;
    u_vout_host_model.wr_cfg(2'h2, 2'h0, 2'h1);
    u_vout_host_model.wr_set(8'h50);
    soft_run(8'h50, k);
    `CHK(k, 20);
    `CHK(refc, 8'h50);
    u_vout_host_model.wr_set(8'h52);
    step_gap(k);
    `CHK(k, 100);
    $display("test programmed restart done");
    report_and_stop();
  end
endmodule // vout_setpoint_dvs_mode_ctrl_bench
`default_nettype wire

// ### verilog/vout_ctrl_map.svh
// Purpose: named constants for the output setpoint and scaling control
// Assumes: 100 MHz system clock
// Notes: times are given in ns, cycle counts derive from them
`ifndef VOUT_CTRL_MAP_SVH
`define VOUT_CTRL_MAP_SVH
`define CLK_PERIOD_NS 10
`define RANGE_1P25 2'h0
`define RANGE_2P5 2'h1
`define RANGE_5 2'h2
`define RANGE_10 2'h3
`define RANGE_DEFAULT 2'h2
`define BASE_LOW_UV 22'h061a80
`define BASE_HIGH_UV 22'h0c3500
`define STEP_1P25_UV 22'h0004e2
`define STEP_2P5_UV 22'h0009c4
`define STEP_5_UV 22'h001388
`define STEP_10_UV 22'h002710
`define STRAP_GND 2'h0
`define STRAP_LOW_PD 2'h1
`define STRAP_HIGH_PU 2'h2
`define STRAP_SUPPLY 2'h3
`define CODE_GND 8'h46
`define CODE_LOW_PD 8'h5a
`define CODE_HIGH_PU 8'h78
`define CODE_SUPPLY 8'h5f
`define CODE_RESET 8'h00
`define SS_DEFAULT 2'h1
`define RAMP_DEFAULT 2'h0
`define STEP_0P5US_NS 500
`define STEP_1US_NS 1000
`define STEP_5US_NS 5000
`define STEP_10US_NS 10000
`define STEP_0P5US_CYC (`STEP_0P5US_NS / `CLK_PERIOD_NS)
`define STEP_1US_CYC (`STEP_1US_NS / `CLK_PERIOD_NS)
`define STEP_5US_CYC (`STEP_5US_NS / `CLK_PERIOD_NS)
`define STEP_10US_CYC (`STEP_10US_NS / `CLK_PERIOD_NS)
`define SS_500US_NS 500000
`define SS_1MS_NS 1000000
`define SS_2MS_NS 2000000
`define SS_4MS_NS 4000000
`define SS_500US_CYC (`SS_500US_NS / `CLK_PERIOD_NS)
`define SS_1MS_CYC (`SS_1MS_NS / `CLK_PERIOD_NS)
`define SS_2MS_CYC (`SS_2MS_NS / `CLK_PERIOD_NS)
`define SS_4MS_CYC (`SS_4MS_NS / `CLK_PERIOD_NS)
`endif

// ### verilog/vout_ctrl_pkg.sv
// Purpose: types for the output setpoint and scaling control
// Assumes: nothing
// Notes: state codes left to the tool
package vout_ctrl_pkg;
  typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_ON} conv_state_t;
endpackage

// ### verilog/vout_setpoint_dvs_mode_ctrl.sv
// Purpose: setpoint, range, soft start, voltage scaling and mode select
// Assumes: all inputs synchronous to clk_sys_i; strap already sensed
// Notes: config values are pended and applied only when no ramp runs
// Function
// - range select 00/01/10 give 0.4 V base with 1.25/2.5/5 mV, 11 gives 0.8 V/10 mV
// - range select holds code 10 after initialization
// - new range used only after a following setpoint register write
// - target voltage is base plus code times step of the active range
// - init loads default code from strap: 46, 5a, 78, 5f
// - sensed strap state also selects the I2C target address
// - setpoint, range and soft-start values deferred until soft start completes
// - soft start ramps to captured code, then ramps to newer code
// - values written while enable is low are used on next enable
// - configuration writes during any ramp wait until the ramp finishes
// - reference moves stepwise toward a new code, up or down
// - ramp rate field gives step period 0.5, 1, 5 or 10 us
// - static high mode pin forces continuous switching, low selects power save unless bit, valid sync or secondary forces continuous
// - valid sync clock aligns switching and forces continuous switching
// - forced continuous is mode pin OR force-continuous bit OR valid sync OR secondary
// - stacked secondary takes mode pin as its switching clock
// - variants without I2C keep range fixed at 0.4 V to 1.675 V
// - soft start duration field selects 500 us, 1, 2 or 4 ms, default 1 ms
// - pin low, bit clear, no valid sync and not secondary selects power save, bit set forces continuous
`timescale 1ns/1ps
`include "vout_ctrl_map.svh"
`default_nettype none
module vout_setpoint_dvs_mode_ctrl
  import vout_ctrl_pkg::*;
#(
  parameter int SS_500US_CYC = `SS_500US_CYC,
  parameter int SS_1MS_CYC = `SS_1MS_CYC,
  parameter int SS_2MS_CYC = `SS_2MS_CYC,
  parameter int SS_4MS_CYC = `SS_4MS_CYC
)
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic init_i,
  input wire logic [1:0] voltage_select_strap_i,
  input wire logic i2c_variant_i,
  input wire logic enable_i,
  input wire logic cfg_wr_i,
  input wire logic [1:0] range_select_i,
  input wire logic [1:0] soft_start_duration_i,
  input wire logic [1:0] scaling_ramp_rate_i,
  input wire logic force_continuous_bit_i,
  input wire logic setpoint_wr_i,
  input wire logic [7:0] setpoint_code_i,
  input wire logic mode_sync_i,
  input wire logic sync_valid_i,
  input wire logic secondary_i,
  output logic init_done_o,
  output logic [1:0] i2c_addr_sel_o,
  output logic [1:0] active_range_o,
  output logic [7:0] target_code_o,
  output logic [7:0] ref_code_o,
  output logic [21:0] target_uv_o,
  output logic [21:0] ref_uv_o,
  output logic soft_start_o,
  output logic ramping_o,
  output logic forced_continuous_switching_o,
  output logic power_save_operation_o,
  output logic sync_align_o,
  output logic ext_clock_input_o
);

  conv_state_t state_reg, state_next;
  logic init_done_reg;
  logic [1:0] strap_reg;
  logic [1:0] pend_range_reg, armed_range_reg, range_reg;
  logic [7:0] pend_code_reg, code_reg, ref_reg, ref_next;
  logic [1:0] pend_ss_reg, ss_reg, pend_ramp_reg, ramp_reg;
  logic [9:0] step_cnt_reg, step_cnt_next;
  logic [18:0] ss_cnt_reg, ss_cnt_next;
  logic fccm_reg, align_reg, extclk_reg;
  logic [21:0] tgt_uv_reg, ref_uv_reg;

  // decode of the step period and soft start length
  wire [9:0] step_period =
    (ramp_reg == 2'h0) ? 10'(`STEP_0P5US_CYC) :
    (ramp_reg == 2'h1) ? 10'(`STEP_1US_CYC) :
    (ramp_reg == 2'h2) ? 10'(`STEP_5US_CYC) : 10'(`STEP_10US_CYC);
  wire [18:0] ss_period =
    (ss_reg == 2'h0) ? 19'(SS_500US_CYC) :
    (ss_reg == 2'h1) ? 19'(SS_1MS_CYC) :
    (ss_reg == 2'h2) ? 19'(SS_2MS_CYC) : 19'(SS_4MS_CYC);

  wire [7:0] strap_code =
    (strap_reg == `STRAP_GND) ? `CODE_GND :
    (strap_reg == `STRAP_LOW_PD) ? `CODE_LOW_PD :
    (strap_reg == `STRAP_HIGH_PU) ? `CODE_HIGH_PU : `CODE_SUPPLY;
  wire [7:0] init_code =
    (voltage_select_strap_i == `STRAP_GND) ? `CODE_GND :
    (voltage_select_strap_i == `STRAP_LOW_PD) ? `CODE_LOW_PD :
    (voltage_select_strap_i == `STRAP_HIGH_PU) ? `CODE_HIGH_PU : `CODE_SUPPLY;

  wire ramping = (state_reg == ST_ON) && (ref_reg != code_reg);
  // off: values apply freely, also on the enabling edge, so a write just before enable is not lost
  wire apply_ok = (state_reg == ST_OFF) || ((state_reg == ST_ON) && !ramping);
  wire step_due = ramping && (step_cnt_reg == step_period - 10'h001);
  wire ss_done = (state_reg == ST_SOFT) && (ss_cnt_reg == ss_period - 19'h00001);
  // a range write alone is never used; a setpoint write arms it
  wire [1:0] range_for_arm = cfg_wr_i ? range_select_i : pend_range_reg;
  wire [1:0] range_apply = i2c_variant_i ? armed_range_reg : `RANGE_DEFAULT;

  always_comb
  begin
    state_next = state_reg;
    ss_cnt_next = 19'h00000;
    ref_next = ref_reg;
    step_cnt_next = 10'h000;
    case (state_reg)
      ST_OFF:
      begin
        ref_next = `CODE_RESET;
        if (enable_i && init_done_reg)
        begin
          state_next = ST_SOFT;
          ref_next = init_i ? init_code : pend_code_reg;
        end
      end
      ST_SOFT:
      begin
        ss_cnt_next = ss_cnt_reg + 19'h00001;
        if (ss_done)
          state_next = ST_ON;
        if (!enable_i)
          state_next = ST_OFF;
      end
      ST_ON:
      begin
        if (ramping)
          step_cnt_next = step_due ? 10'h000 : step_cnt_reg + 10'h001;
        if (step_due)
          ref_next = (code_reg > ref_reg) ? ref_reg + 8'h01 : ref_reg - 8'h01;
        if (!enable_i)
          state_next = ST_OFF;
      end
      default:
        state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= ST_OFF;
      ss_cnt_reg <= 19'h00000;
      step_cnt_reg <= 10'h000;
      ref_reg <= `CODE_RESET;
    end
    else
    begin
      state_reg <= state_next;
      ss_cnt_reg <= ss_cnt_next;
      step_cnt_reg <= step_cnt_next;
      ref_reg <= ref_next;
    end
  end

  // strap and defaults are caught on the init pulse, not at reset
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      init_done_reg <= 1'b0;
      strap_reg <= `STRAP_GND;
      pend_range_reg <= `RANGE_DEFAULT;
      armed_range_reg <= `RANGE_DEFAULT;
      pend_code_reg <= `CODE_RESET;
      pend_ss_reg <= `SS_DEFAULT;
      pend_ramp_reg <= `RAMP_DEFAULT;
    end
    else if (init_i)
    begin
      init_done_reg <= 1'b1;
      strap_reg <= voltage_select_strap_i;
      pend_range_reg <= `RANGE_DEFAULT;
      armed_range_reg <= `RANGE_DEFAULT;
      pend_code_reg <= init_code;
      pend_ss_reg <= `SS_DEFAULT;
      pend_ramp_reg <= `RAMP_DEFAULT;
    end
    else
    begin
      if (cfg_wr_i)
      begin
        pend_range_reg <= range_select_i;
        pend_ss_reg <= soft_start_duration_i;
        pend_ramp_reg <= scaling_ramp_rate_i;
      end
      if (setpoint_wr_i)
      begin
        pend_code_reg <= setpoint_code_i;
        armed_range_reg <= range_for_arm;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      range_reg <= `RANGE_DEFAULT;
      code_reg <= `CODE_RESET;
      ss_reg <= `SS_DEFAULT;
      ramp_reg <= `RAMP_DEFAULT;
    end
    else if (init_i)
    begin
      range_reg <= `RANGE_DEFAULT;
      code_reg <= init_code;
      ss_reg <= `SS_DEFAULT;
      ramp_reg <= `RAMP_DEFAULT;
    end
    else if (apply_ok)
    begin
      range_reg <= range_apply;
      code_reg <= pend_code_reg;
      ss_reg <= pend_ss_reg;
      ramp_reg <= pend_ramp_reg;
    end
    else if (!i2c_variant_i)
      range_reg <= `RANGE_DEFAULT;
  end

  // voltage of a code in microvolts
  function automatic logic [21:0] code_uv(input logic [1:0] rng, input logic [7:0] code);
    logic [21:0] step;
    logic [21:0] base;
    step = (rng == `RANGE_1P25) ? `STEP_1P25_UV :
           (rng == `RANGE_2P5) ? `STEP_2P5_UV :
           (rng == `RANGE_5) ? `STEP_5_UV : `STEP_10_UV;
    base = (rng == `RANGE_10) ? `BASE_HIGH_UV : `BASE_LOW_UV;
    code_uv = base + 22'(step * {14'h0000, code});
  endfunction

  // mode pin level is only meaningful without a sync clock
  wire fccm_next = mode_sync_i || force_continuous_bit_i || sync_valid_i || secondary_i;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fccm_reg <= 1'b0;
      align_reg <= 1'b0;
      extclk_reg <= 1'b0;
      tgt_uv_reg <= `BASE_LOW_UV;
      ref_uv_reg <= `BASE_LOW_UV;
    end
    else
    begin
      fccm_reg <= fccm_next;
      align_reg <= sync_valid_i || secondary_i;
      extclk_reg <= secondary_i;
      tgt_uv_reg <= code_uv(range_reg, code_reg);
      ref_uv_reg <= code_uv(range_reg, ref_reg);
    end
  end

  assign init_done_o = init_done_reg;
  assign i2c_addr_sel_o = strap_reg;
  assign active_range_o = range_reg;
  assign target_code_o = code_reg;
  assign ref_code_o = ref_reg;
  assign target_uv_o = tgt_uv_reg;
  assign ref_uv_o = ref_uv_reg;
  assign soft_start_o = (state_reg == ST_SOFT);
  assign ramping_o = ramping;
  assign forced_continuous_switching_o = fccm_reg;
  assign power_save_operation_o = !fccm_reg;
  assign sync_align_o = align_reg;
  assign ext_clock_input_o = extclk_reg;

  chk_init_range: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    init_i |=> active_range_o == `RANGE_DEFAULT)
    else $error("range not default after init");
  chk_strap_code: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    init_i |=> (target_code_o == strap_code) && (i2c_addr_sel_o == $past(voltage_select_strap_i)))
    else $error("strap default code or address wrong");
  chk_range_armed: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ($changed(active_range_o) && !$past(init_i) && $past(i2c_variant_i)) |-> active_range_o == $past(armed_range_reg))
    else $error("range used without setpoint write");
  chk_ss_frozen: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (soft_start_o && $past(soft_start_o) && !$past(init_i)) |-> $stable(target_code_o) && $stable(ref_code_o))
    else $error("values changed during soft start");
  chk_ramp_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ($past(ramping) && !$past(init_i)) |-> $stable(target_code_o) && $stable(active_range_o))
    else $error("config applied during ramp");
  chk_step_unit: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ($past(state_reg == ST_ON) && state_reg == ST_ON && $changed(ref_code_o)) |->
      (ref_code_o == $past(ref_code_o) + 8'h01) || (ref_code_o == $past(ref_code_o) - 8'h01))
    else $error("reference jumped");
  chk_step_bound: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ramping |-> step_cnt_reg < step_period)
    else $error("step counter past period");
  chk_step_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ramping && step_cnt_reg != step_period - 10'h001 && enable_i) |=> $stable(ref_code_o))
    else $error("reference stepped early");
  chk_ss_length: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ($past(soft_start_o) && state_reg == ST_ON) |-> $past(ss_cnt_reg) == $past(ss_period) - 19'h00001)
    else $error("soft start length wrong");
  chk_mode_or: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (!mode_sync_i && !force_continuous_bit_i && !sync_valid_i && !secondary_i) |=> power_save_operation_o)
    else $error("power save not selected");
  chk_fixed_range: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !i2c_variant_i |=> active_range_o == `RANGE_DEFAULT)
    else $error("range not fixed without i2c");

  cov_ss_done: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) soft_start_o ##1 (state_reg == ST_ON));
  cov_ramp_up: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) ramping && (code_reg > ref_reg));
  cov_ramp_down: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) ramping && (code_reg < ref_reg));
  cov_wr_in_ss: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) soft_start_o && setpoint_wr_i);

endmodule // vout_setpoint_dvs_mode_ctrl
`default_nettype wire
